// *** cdac_ctrl.sv ***
/*
 Current DAC update control: Avalon-MM register slave, trigger selection,
 staging latch and active output word driven to the analog current core.
 Assumes timer overflow inputs are one-cycle pulses on clk_sys and that the
 convert-start pin is asynchronous.
*/
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "cdac_map.svh"
module cdac_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [`CDAC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Trigger events
   input wire cdac_pkg::cdac_evt_t evt,
   // Analog core
   output cdac_pkg::cdac_ana_t ana,
   output logic update_pulse
);
   import cdac_pkg::*;

   cdac_state_t st_ff;
   cdac_state_t nxt_st;

   function automatic logic [2:0] fsr_decode(input logic [1:0] code);
      logic [2:0] r;
      r = 3'h0;
      case (code)
         `CDAC_FSR_025: r = 3'h1;
         `CDAC_FSR_050: r = 3'h2;
         `CDAC_FSR_100: r = 3'h4;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   logic [2:0] sel;
   logic rise;
   logic fall;
   logic trig;
   logic wr_ctrl;
   logic wr_data;
   logic req;

   assign sel = st_ff.ctrl[`CDAC_SEL_HI:`CDAC_SEL_LO];
   // Edges are taken from the second synchroniser stage against its delayed copy,
   // so a metastable first stage never reaches the edge detector.
   assign rise = st_ff.pin_s2 & ~st_ff.pin_prev;
   assign fall = ~st_ff.pin_s2 & st_ff.pin_prev;
   assign req = avs_read | avs_write;
   // Writes take effect only in the acknowledge cycle, once per request.
   assign wr_ctrl = avs_write && st_ff.bus_st == CDAC_ACK && avs_address == `CDAC_OFS_CTRL
                    && avs_byteenable[0];
   assign wr_data = avs_write && st_ff.bus_st == CDAC_ACK && avs_address == `CDAC_OFS_DATA
                    && avs_byteenable[0];

   // Only the selected source can move the output; all other timer pulses and
   // pin edges are dropped, since nothing is queued for a later mode change.
   always_comb begin
      case (sel)
         `CDAC_TRG_T0: trig = evt.tmr_ovf[0];
         `CDAC_TRG_T1: trig = evt.tmr_ovf[1];
         `CDAC_TRG_T2: trig = evt.tmr_ovf[2];
         `CDAC_TRG_T3: trig = evt.tmr_ovf[3];
         `CDAC_TRG_RISE: trig = rise;
         `CDAC_TRG_FALL: trig = fall;
         `CDAC_TRG_ANY: trig = rise | fall;
         `CDAC_TRG_WRITE: trig = wr_data;
         default: trig = 1'b0;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pin_s1 = evt.conv_pin;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.pin_prev = st_ff.pin_s2;
      nxt_st.update = 1'b0;
      case (st_ff.bus_st)
         CDAC_IDLE: begin
            if (req) begin
               nxt_st.bus_st = CDAC_ACK;
            end
         end
         CDAC_ACK: begin
            nxt_st.bus_st = CDAC_IDLE;
         end
         default: nxt_st.bus_st = CDAC_IDLE;
      endcase
      // Read data is prepared while the request waits, so it stands at the ack edge.
      if (avs_read && st_ff.bus_st == CDAC_IDLE) begin
         case (avs_address)
            `CDAC_OFS_CTRL: nxt_st.rdata = {24'h000000, st_ff.ctrl};
            `CDAC_OFS_DATA: nxt_st.rdata = {24'h000000, st_ff.staged};
            `CDAC_OFS_ACTIVE: nxt_st.rdata = {24'h000000, st_ff.active};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
      if (wr_ctrl) begin
         // Bit 2 is masked so it always reads back zero.
         nxt_st.ctrl = avs_writedata[7:0] & `CDAC_CTRL_WMASK;
      end
      if (wr_data) begin
         nxt_st.staged = avs_writedata[7:0];
      end
      if (trig) begin
         // In direct mode the written word bypasses staging.
         nxt_st.active = (sel == `CDAC_TRG_WRITE) ? avs_writedata[7:0] : st_ff.staged;
         nxt_st.update = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      // The synchroniser restarts low, so a pin that idles high shows one rising
      // edge shortly after reset; software should select the pin only afterwards.
      if (!rst_n) begin
         st_ff <= '{bus_st: CDAC_IDLE, rdata: 32'h00000000, ctrl: `CDAC_CTRL_RST,
                    staged: `CDAC_DATA_RST, active: `CDAC_DATA_RST, pin_s1: 1'b0,
                    pin_s2: 1'b0, pin_prev: 1'b0, update: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Every request sees exactly one wait cycle, so the master never needs a count.
   assign avs_waitrequest = req && st_ff.bus_st != CDAC_ACK;
   assign avs_readdata = st_ff.rdata;
   assign update_pulse = st_ff.update;
   // The analog core sees registered values, except full_scale_onehot, which is decoded from registered ctrl bits.
   assign ana = '{
      dac_word: st_ff.active,
      constant_supply_sel: st_ff.ctrl[`CDAC_CSC_BIT],
      full_scale_onehot: fsr_decode(st_ff.ctrl[`CDAC_FSR_HI:`CDAC_FSR_LO])
   };

   // Timer sources: the selected overflow loads the staged word one edge later.
   a_timer_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T1 && evt.tmr_ovf[1] && !wr_data) |=> ana.dac_word == $past(st_ff.staged))
      else $error("timer 1 overflow did not load staged word");

   a_timer2_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T2 && evt.tmr_ovf[2]) |=> ana.dac_word == $past(st_ff.staged))
      else $error("timer 2 overflow did not load staged word");

   a_timer3_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T3 && evt.tmr_ovf[3]) |=> ana.dac_word == $past(st_ff.staged))
      else $error("timer 3 overflow did not load staged word");

   a_timer1_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T1 && evt.tmr_ovf[1]) |=> update_pulse)
      else $error("timer 1 overflow gave no update pulse");

   a_timer2_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T2 && evt.tmr_ovf[2]) |=> update_pulse)
      else $error("timer 2 overflow gave no update pulse");

   a_timer3_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T3 && evt.tmr_ovf[3]) |=> update_pulse)
      else $error("timer 3 overflow gave no update pulse");

   // Without its own overflow a timer mode must stay quiet.
   a_t1_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T1 && !evt.tmr_ovf[1]) |=> !update_pulse)
      else $error("timer 1 mode updated without its overflow");

   a_t2_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T2 && !evt.tmr_ovf[2]) |=> !update_pulse)
      else $error("timer 2 mode updated without its overflow");

   a_t3_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T3 && !evt.tmr_ovf[3]) |=> !update_pulse)
      else $error("timer 3 mode updated without its overflow");

   a_timer0_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T0 && evt.tmr_ovf[0] && !wr_ctrl) |=> update_pulse)
      else $error("timer 0 overflow did not update");

   a_timer0_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T0 && evt.tmr_ovf[0]) |=> ana.dac_word == $past(st_ff.staged))
      else $error("timer 0 overflow did not load staged word");

   a_t0_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_T0 && !evt.tmr_ovf[0]) |=> !update_pulse)
      else $error("timer 0 mode updated without its overflow");

   // Pin sources: edges are judged on the synchronised level only.
   a_rise_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_RISE && $rose(st_ff.pin_s2) && $stable(sel)) |=> update_pulse)
      else $error("rising pin edge did not update");

   a_rise_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_RISE && st_ff.pin_s2 && !st_ff.pin_prev)
      |=> ana.dac_word == $past(st_ff.staged))
      else $error("rising pin edge did not load staged word");

   a_rise_no_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_RISE && !st_ff.pin_s2 && st_ff.pin_prev) |=> !update_pulse)
      else $error("falling pin edge updated in rising mode");

   a_fall_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_FALL && $fell(st_ff.pin_s2) && $stable(sel)) |=> update_pulse)
      else $error("falling pin edge did not update");

   a_fall_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_FALL && !st_ff.pin_s2 && st_ff.pin_prev)
      |=> ana.dac_word == $past(st_ff.staged))
      else $error("falling pin edge did not load staged word");

   a_fall_no_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_FALL && st_ff.pin_s2 && !st_ff.pin_prev) |=> !update_pulse)
      else $error("rising pin edge updated in falling mode");

   a_any_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_ANY && st_ff.pin_s2 != st_ff.pin_prev) |=> update_pulse)
      else $error("pin edge did not update");

   a_any_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_ANY && st_ff.pin_s2 != st_ff.pin_prev)
      |=> ana.dac_word == $past(st_ff.staged))
      else $error("pin edge did not load staged word");

   a_any_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_ANY && st_ff.pin_s2 == st_ff.pin_prev) |=> !update_pulse)
      else $error("any edge mode updated on a steady pin");

   // Direct mode: the write itself is the trigger and nothing else is.
   a_direct_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_WRITE && wr_data) |=> ana.dac_word == $past(avs_writedata[7:0]))
      else $error("direct write did not reach output");

   a_direct_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_WRITE && wr_data) |=> update_pulse)
      else $error("direct write gave no update pulse");

   a_direct_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_WRITE && !wr_data) |=> !update_pulse)
      else $error("direct mode updated without a data write");

   a_direct_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel == `CDAC_TRG_WRITE && wr_data) |=> ana.dac_word == st_ff.staged)
      else $error("direct write left staging and output apart");

   // Control fields: stored on an acknowledged write and held otherwise.
   a_csc_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl |=> ana.constant_supply_sel == $past(avs_writedata[3]))
      else $error("constant supply bit not stored");

   a_csc_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_ctrl && !avs_writedata[`CDAC_CSC_BIT]) |=> !ana.constant_supply_sel)
      else $error("constant supply bit not cleared");

   a_csc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_ctrl |=> $stable(ana.constant_supply_sel))
      else $error("constant supply bit changed without a write");

   a_rsv_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_ff.ctrl[`CDAC_RSV_BIT] == 1'b0)
      else $error("reserved bit not zero");

   a_rsv_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_ctrl && avs_writedata[`CDAC_RSV_BIT]) |=> !st_ff.ctrl[`CDAC_RSV_BIT])
      else $error("reserved bit took a written one");

   a_rsv_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (avs_read && st_ff.bus_st == CDAC_IDLE && avs_address == `CDAC_OFS_CTRL)
      |=> !avs_readdata[`CDAC_RSV_BIT])
      else $error("reserved bit read back as one");

   a_fsr_onehot: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl && avs_writedata[1:0] == `CDAC_FSR_100 |=> ana.full_scale_onehot == 3'h4)
      else $error("full scale decode wrong");

   a_fsr_quarter: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl && avs_writedata[1:0] == `CDAC_FSR_025 |=> ana.full_scale_onehot == 3'h1)
      else $error("quarter full scale decode wrong");

   a_fsr_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl && avs_writedata[1:0] == `CDAC_FSR_050 |=> ana.full_scale_onehot == 3'h2)
      else $error("half full scale decode wrong");

   a_fsr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_ctrl |=> $stable(ana.full_scale_onehot))
      else $error("full scale changed without a write");

   // Staging: a written word waits for its trigger before it reaches the core.
   a_no_trig_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !trig |=> $stable(ana.dac_word))
      else $error("output changed without trigger");

   a_stage_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_data |=> st_ff.staged == $past(avs_writedata[7:0]))
      else $error("data write did not reach staging");

   a_stage_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sel != `CDAC_TRG_WRITE && wr_data && !trig) |=> $stable(ana.dac_word))
      else $error("staged word reached output without trigger");

   a_pulse_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !update_pulse |-> $stable(ana.dac_word))
      else $error("output moved without an update pulse");
endmodule

// *** cdac_map.svh ***
/*
 Register offsets, field positions, reset values and trigger encodings for the
 current DAC update control. Assumes inclusion by the package and the design.
*/
`ifndef CDAC_MAP_SVH
`define CDAC_MAP_SVH
`define CDAC_ADDR_W 2
`define CDAC_OFS_CTRL 2'h0
`define CDAC_OFS_DATA 2'h1
`define CDAC_OFS_ACTIVE 2'h2
`define CDAC_CTRL_RST 8'h00
`define CDAC_DATA_RST 8'h00
`define CDAC_SEL_HI 6
`define CDAC_SEL_LO 4
`define CDAC_CSC_BIT 3
`define CDAC_RSV_BIT 2
`define CDAC_FSR_HI 1
`define CDAC_FSR_LO 0
`define CDAC_CTRL_WMASK 8'hFB
`define CDAC_TRG_T0 3'h0
`define CDAC_TRG_T1 3'h1
`define CDAC_TRG_T2 3'h2
`define CDAC_TRG_T3 3'h3
`define CDAC_TRG_RISE 3'h4
`define CDAC_TRG_FALL 3'h5
`define CDAC_TRG_ANY 3'h6
`define CDAC_TRG_WRITE 3'h7
`define CDAC_FSR_025 2'h0
`define CDAC_FSR_050 2'h1
`define CDAC_FSR_100 2'h2
`endif

// *** cdac_pkg.sv ***
/*
 Types shared by the current DAC update control.
 Assumes the constant header is on the include path.
*/
package cdac_pkg;
`include "cdac_map.svh"
   typedef enum logic [1:0] {CDAC_IDLE, CDAC_ACK} cdac_bus_st_t;

   typedef struct packed {
      logic [3:0] tmr_ovf;
      logic conv_pin;
   } cdac_evt_t;

   typedef struct packed {
      logic [7:0] dac_word;
      logic constant_supply_sel;
      logic [2:0] full_scale_onehot;
   } cdac_ana_t;

   typedef struct packed {
      cdac_bus_st_t bus_st;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic [7:0] staged;
      logic [7:0] active;
      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      logic update;
   } cdac_state_t;
endpackage

// *** cdac_evt_model.sv ***
/*
 Timer and convert-start pin model for the DAC update control.
 Assumes the bench requests overflows and pin levels just after a clock edge.
*/
`timescale 1ns/1ns
module cdac_evt_model (
   // Clock
   input wire logic clk_sys,
   // Bench requests
   input wire logic [3:0] fire,
   input wire logic pin_lvl,
   // Events to the block
   output cdac_pkg::cdac_evt_t evt
);
   import cdac_pkg::*;
   // Timers overflow on a clk_sys edge, so pulses come out registered.
   always_ff @(posedge clk_sys) begin
      evt.tmr_ovf <= fire;
      evt.conv_pin <= pin_lvl;
   end
endmodule

// *** testbench.sv ***
/*
 Self-checking bench for the current DAC update control.
 Assumes the block answers each Avalon request within a few cycles.
*/
`timescale 1ns/1ns
`include "cdac_map.svh"
module testbench;
   import cdac_pkg::*;
   logic clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, pin_lvl = 0;
   logic [1:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hF, fire = 0;
   logic avs_waitrequest, update_pulse;
   cdac_evt_t evt;
   cdac_ana_t ana;
   int err_total = 0, checks = 0;
   logic [7:0] q, cur;
   cdac_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .evt(evt), .ana(ana), .update_pulse(update_pulse));
   cdac_evt_model model (.clk_sys(clk_sys), .fire(fire), .pin_lvl(pin_lvl), .evt(evt));
   initial forever #25 clk_sys = ~clk_sys;
   task automatic print_verdict();
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e, input string nm);
      checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge.
   task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      // Read data is taken at the same edge that shows waitrequest low.
      q = avs_readdata[7:0];
      if (avs_waitrequest !== 1'b0) begin
         err_total++;
         print_verdict();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic t_regs();
      bus(0, `CDAC_OFS_CTRL, 8'h00);
      chk(q, `CDAC_CTRL_RST, "ctrl reset");
      chk({5'h0, ana.full_scale_onehot}, 8'h01, "fsr reset");
      bus(1, `CDAC_OFS_CTRL, 8'h7F);
      bus(0, `CDAC_OFS_CTRL, 8'h00);
      chk(q, 8'h7B, "ctrl bit2");
      wt(1);
      chk({7'h0, ana.constant_supply_sel}, 8'h01, "supply sel");
      for (int f = 0; f < 3; f++) begin
         bus(1, `CDAC_OFS_CTRL, 8'(f));
         wt(1);
         chk({5'h0, ana.full_scale_onehot}, 8'h01 << f, "fsr");
      end
      chk({7'h0, ana.constant_supply_sel}, 8'h00, "supply clear");
      // Lane 0 off must leave the control register untouched.
      avs_byteenable <= 4'hE;
      bus(1, `CDAC_OFS_CTRL, 8'h0B);
      avs_byteenable <= 4'hF;
      bus(0, `CDAC_OFS_CTRL, 8'h00);
      chk(q, 8'h02, "lane off");
      bus(0, 2'h3, 8'h00);
      chk(q, 8'h00, "unmapped");
   endtask
   task automatic t_timers();
      cur = ana.dac_word;
      for (int t = 0; t < 4; t++) begin
         bus(1, `CDAC_OFS_CTRL, 8'(t << 4));
         bus(1, `CDAC_OFS_DATA, 8'h10 + 8'(t));
         fire <= 4'h1 << ((t + 1) % 4);
         wt(1);
         fire <= 4'h0;
         wt(4);
         chk(ana.dac_word, cur, "staged word");
         fire <= 4'h1 << t;
         wt(1);
         fire <= 4'h0;
         wt(4);
         cur = 8'h10 + 8'(t);
         chk(ana.dac_word, cur, "timer load");
      end
   endtask
   task automatic t_pin();
      for (int s = 4; s < 7; s++) begin
         bus(1, `CDAC_OFS_CTRL, 8'(s << 4));
         bus(1, `CDAC_OFS_DATA, 8'hA0 + 8'(s));
         pin_lvl <= 1'b1;
         wt(7);
         if (s != 5) cur = 8'hA0 + 8'(s);
         chk(ana.dac_word, cur, "pin rise");
         bus(1, `CDAC_OFS_DATA, 8'hB0 + 8'(s));
         pin_lvl <= 1'b0;
         wt(7);
         if (s != 4) cur = 8'hB0 + 8'(s);
         chk(ana.dac_word, cur, "pin fall");
      end
   endtask
   initial begin
      wt(5);
      rst_n <= 1'b1;
      wt(1);
      t_regs();
      t_timers();
      t_pin();
      bus(1, `CDAC_OFS_CTRL, 8'h70);
      bus(1, `CDAC_OFS_DATA, 8'h5A);
      chk(ana.dac_word, 8'h5A, "direct");
      chk({7'h0, update_pulse}, 8'h01, "update pulse");
      print_verdict();
   end
endmodule
